// file: socr_pkg.sv
// Constants shared by the serial output control register bank.
// Assumes one 250 MHz ref_clk domain and an APB master on the far side.
`default_nettype none

package socr_pkg;

   // ***********************************************************
   // Bus and datapath sizes
   // ***********************************************************
   localparam int          ADDR_W     = 16;
   localparam int          DATA_W     = 32;
   localparam int          REG_W      = 8;
   localparam int          SAMPLE_W   = 14;
   localparam int          NUM_VC     = 4;
   localparam int          SYNC_DEPTH = 3;

   // ***********************************************************
   // Register indices; byte address is four times the index
   // ***********************************************************
   localparam logic [13:0] IDX_OUT_FMT  = 14'h0561;
   localparam logic [13:0] IDX_OR_CLR   = 14'h0562;
   localparam logic [13:0] IDX_OR_STAT  = 14'h0563;
   localparam logic [13:0] IDX_RATE     = 14'h056e;
   localparam logic [13:0] IDX_PLL_STAT = 14'h056f;
   localparam logic [13:0] IDX_QUICK    = 14'h0570;

   // ***********************************************************
   // Field positions
   // ***********************************************************
   localparam int          FMT_LSB   = 0;
   localparam int          INV_BIT   = 2;
   localparam int          RATE_BIT  = 4;
   localparam int          LOCK_BIT  = 7;
   localparam int          LANE_LSB  = 6;
   localparam int          CONV_LSB  = 3;
   localparam int          OCT_LSB   = 0;

   // ***********************************************************
   // Encodings, writable masks and reset values
   // ***********************************************************
   localparam logic [1:0]  FMT_OFFSET   = 2'h0;
   localparam logic [1:0]  FMT_TWOS     = 2'h1;
   localparam logic [7:0]  MASK_OUT_FMT = 8'h07;
   localparam logic [7:0]  MASK_OR_CLR  = 8'h0f;
   localparam logic [7:0]  MASK_RATE    = 8'h10;
   localparam logic [7:0]  RST_OUT_FMT  = 8'h01;
   localparam logic [7:0]  RST_OR_CLR   = 8'h00;
   localparam logic [7:0]  RST_RATE     = 8'h10;
   localparam logic [7:0]  RST_QUICK    = 8'h80;

endpackage

`default_nettype wire

// file: socr_or_flag.sv
// One sticky overrange flag for a single virtual converter.
// Assumes the event comes from logic on ref_clk, so no synchroniser.
`default_nettype none

module socr_or_flag (
   input  wire logic ref_clk,    // Sample clock
   input  wire logic reset_n,    // Async reset, active low
   input  wire logic or_event,   // Overrange seen this cycle
   input  wire logic or_clear,   // Clear control level
   output var  logic or_flag     // Sticky flag
);

   typedef struct packed {
      logic flag;
   } socr_flag_s;

   socr_flag_s st_reg;
   socr_flag_s st_next;

   // Clear held high wins: the flag is held cleared, not pulsed
   always_comb begin
      st_next = st_reg;
      if (or_clear) begin
         st_next.flag = 1'b0;
      end else if (or_event) begin
         st_next.flag = 1'b1;
      end
   end

   // State register
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign or_flag = st_reg.flag;

   a_flag_sticky: assert property (@(posedge ref_clk) disable iff (!reset_n)
      (or_flag && !or_clear) |=> or_flag)
      else $error("overrange flag dropped without clear");

   a_flag_held_clear: assert property (@(posedge ref_clk) disable iff (!reset_n)
      or_clear |=> !or_flag)
      else $error("overrange flag set while clear held");

   a_flag_set_event: assert property (@(posedge ref_clk) disable iff (!reset_n)
      (or_event && !or_clear) |=> or_flag)
      else $error("overrange event not recorded");

endmodule

`default_nettype wire

// file: socr_regs.sv
// Serial output control register bank with APB slave and sample path.
// Assumes an APB3 master on ref_clk and a PLL lock level from another domain.
`default_nettype none

module socr_regs (
   input  wire logic                          ref_clk,         // 250 MHz clock
   input  wire logic                          reset_n,         // Async reset, active low
   input  wire logic                          psel,            // APB select
   input  wire logic                          penable,         // APB access phase
   input  wire logic                          pwrite,          // APB direction
   input  wire logic [socr_pkg::ADDR_W-1:0]   paddr,           // APB byte address
   input  wire logic [socr_pkg::DATA_W-1:0]   pwdata,          // APB write data
   output var  logic [socr_pkg::DATA_W-1:0]   prdata,          // APB read data
   output var  logic                          pready,          // APB ready
   output var  logic                          pslverr,         // APB error
   input  wire logic [socr_pkg::SAMPLE_W-1:0] sample_in,       // Core sample, two's complement
   output var  logic [socr_pkg::SAMPLE_W-1:0] sample_out,      // Formatted sample
   input  wire logic [socr_pkg::NUM_VC-1:0]   or_event,        // Overrange per converter
   output var  logic [socr_pkg::NUM_VC-1:0]   or_flags,        // Sticky overrange flags
   input  wire logic                          pll_locked_pin,  // Serial PLL lock, async
   output var  logic                          lane_rate_low,   // Low lane rate range
   output var  logic [1:0]                    lane_exp,        // Log2 of lane count
   output var  logic [2:0]                    conv_exp,        // Log2 of converter count
   output var  logic [2:0]                    octet_exp        // Log2 of octets per frame
);

   // ***********************************************************
   // Byte addresses of the registers
   // ***********************************************************
   localparam logic [socr_pkg::ADDR_W-1:0] A_OUT_FMT  = {socr_pkg::IDX_OUT_FMT, 2'h0};
   localparam logic [socr_pkg::ADDR_W-1:0] A_OR_CLR   = {socr_pkg::IDX_OR_CLR, 2'h0};
   localparam logic [socr_pkg::ADDR_W-1:0] A_OR_STAT  = {socr_pkg::IDX_OR_STAT, 2'h0};
   localparam logic [socr_pkg::ADDR_W-1:0] A_RATE     = {socr_pkg::IDX_RATE, 2'h0};
   localparam logic [socr_pkg::ADDR_W-1:0] A_PLL_STAT = {socr_pkg::IDX_PLL_STAT, 2'h0};
   localparam logic [socr_pkg::ADDR_W-1:0] A_QUICK    = {socr_pkg::IDX_QUICK, 2'h0};

   // ***********************************************************
   // State
   // ***********************************************************
   typedef struct packed {
      logic [7:0]                    out_fmt;
      logic [7:0]                    or_clr;
      logic [7:0]                    rate;
      logic [7:0]                    quick;
      logic [socr_pkg::SYNC_DEPTH-1:0] lock_sync;
      logic                          lock;
      logic [socr_pkg::SAMPLE_W-1:0] sample;
      logic [socr_pkg::DATA_W-1:0]   rdata;
      logic                          err;
   } socr_state_s;

   socr_state_s st_reg;
   socr_state_s st_next;

   logic        setup_ph;
   logic        write_ev;
   logic        mapped;
   logic [7:0]  rd_byte;
   logic [7:0]  wbyte;
   logic [socr_pkg::SAMPLE_W-1:0] shaped;

   // ***********************************************************
   // Overrange flags, one cell per virtual converter
   // ***********************************************************
   genvar gi;
   generate
      for (gi = 0; gi < socr_pkg::NUM_VC; gi++) begin : g_flag
         socr_or_flag u_flag (
            .ref_clk  (ref_clk),
            .reset_n  (reset_n),
            .or_event (or_event[gi]),
            .or_clear (st_reg.or_clr[gi]),
            .or_flag  (or_flags[gi])
         );
      end
   endgenerate

   // ***********************************************************
   // Bus decode
   // ***********************************************************

   // Zero wait states: the read word is latched in the setup cycle
   assign setup_ph = psel && !penable;
   assign write_ev = psel && penable && pwrite && !st_reg.err;
   assign wbyte    = pwdata[7:0];

   // Address match, unaligned or unknown addresses answer with an error
   always_comb begin
      mapped  = 1'b1;
      rd_byte = 8'h00;
      case (paddr)
         A_OUT_FMT:  rd_byte = st_reg.out_fmt;
         A_OR_CLR:   rd_byte = st_reg.or_clr;
         A_OR_STAT:  rd_byte = {4'h0, or_flags};
         A_RATE:     rd_byte = st_reg.rate;
         A_PLL_STAT: rd_byte = {st_reg.lock, 7'h00};
         A_QUICK:    rd_byte = st_reg.quick;
         default:    mapped  = 1'b0;
      endcase
   end

   // ***********************************************************
   // Sample shaping
   // ***********************************************************

   // Invert first, then flip the sign bit for offset binary
   always_comb begin
      shaped = sample_in;
      if (st_reg.out_fmt[socr_pkg::INV_BIT]) begin
         shaped = ~sample_in;
      end
      if (st_reg.out_fmt[socr_pkg::FMT_LSB +: 2] == socr_pkg::FMT_OFFSET) begin
         shaped[socr_pkg::SAMPLE_W-1] = ~shaped[socr_pkg::SAMPLE_W-1];
      end
   end

   // ***********************************************************
   // Next state
   // ***********************************************************
   always_comb begin
      st_next        = st_reg;
      st_next.sample = shaped;

      // Read data and error are captured once per transfer
      if (setup_ph) begin
         st_next.err   = !mapped;
         st_next.rdata = {24'h000000, rd_byte};
      end

      // Writes land only at the completing access edge
      if (write_ev) begin
         case (paddr)
            A_OUT_FMT: st_next.out_fmt = wbyte & socr_pkg::MASK_OUT_FMT;
            A_OR_CLR:  st_next.or_clr  = wbyte & socr_pkg::MASK_OR_CLR;
            A_RATE:    st_next.rate    = wbyte & socr_pkg::MASK_RATE;
            A_QUICK:   st_next.quick   = wbyte;
            default:   st_next.rate    = st_reg.rate;
         endcase
      end

      // Lock level: first flop feeds only the second, change taken on agreement
      st_next.lock_sync = {st_reg.lock_sync[1:0], pll_locked_pin};
      if (st_reg.lock_sync[1] == st_reg.lock_sync[2]) begin
         st_next.lock = st_reg.lock_sync[2];
      end
   end

   // ***********************************************************
   // State register
   // ***********************************************************
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         st_reg           <= '0;
         st_reg.out_fmt   <= socr_pkg::RST_OUT_FMT;
         st_reg.or_clr    <= socr_pkg::RST_OR_CLR;
         st_reg.rate      <= socr_pkg::RST_RATE;
         st_reg.quick     <= socr_pkg::RST_QUICK;
      end else begin
         st_reg <= st_next;
      end
   end

   // ***********************************************************
   // Outputs
   // ***********************************************************

   // Error is shown only in the access phase; read data is driven in every cycle
   assign pready        = 1'b1;
   assign pslverr       = psel && penable && st_reg.err;
   assign prdata        = st_reg.rdata;
   assign sample_out    = st_reg.sample;
   assign lane_rate_low = st_reg.rate[socr_pkg::RATE_BIT];
   assign lane_exp      = st_reg.quick[socr_pkg::LANE_LSB +: 2];
   assign conv_exp      = st_reg.quick[socr_pkg::CONV_LSB +: 3];
   assign octet_exp     = st_reg.quick[socr_pkg::OCT_LSB +: 3];

   // ***********************************************************
   // Assertions
   // ***********************************************************
   a_invert_path: assert property (@(posedge ref_clk) disable iff (!reset_n)
      (st_reg.out_fmt == 8'h05) |=> (sample_out == ~$past(sample_in)))
      else $error("inverted two's complement sample wrong");

   a_plain_path: assert property (@(posedge ref_clk) disable iff (!reset_n)
      (st_reg.out_fmt == 8'h01) |=> (sample_out == $past(sample_in)))
      else $error("plain sample not passed unchanged");

   a_offset_fmt: assert property (@(posedge ref_clk) disable iff (!reset_n)
      (st_reg.out_fmt == 8'h00) |=> (sample_out == ($past(sample_in) ^ 14'h2000)))
      else $error("offset binary sample wrong");

   a_status_read: assert property (@(posedge ref_clk) disable iff (!reset_n)
      (setup_ph && !pwrite && paddr == A_OR_STAT) |=> (prdata == {28'h0000000, $past(or_flags)}))
      else $error("overrange status read wrong");

   a_lock_follow: assert property (@(posedge ref_clk) disable iff (!reset_n)
      (st_reg.lock_sync[1] == st_reg.lock_sync[2]) |=> (st_reg.lock == $past(st_reg.lock_sync[2])))
      else $error("lock bit did not follow agreed level");

   a_lock_filter: assert property (@(posedge ref_clk) disable iff (!reset_n)
      $changed(st_reg.lock) |-> $past(st_reg.lock_sync[1] == st_reg.lock_sync[2]))
      else $error("lock bit changed without agreement");

   a_rate_write: assert property (@(posedge ref_clk) disable iff (!reset_n)
      (write_ev && paddr == A_RATE) |=> (lane_rate_low == $past(pwdata[4]) && st_reg.rate[3:0] == 4'h0))
      else $error("lane rate write wrong");

   a_quick_fields: assert property (@(posedge ref_clk) disable iff (!reset_n)
      (write_ev && paddr == A_QUICK) |=> (lane_exp == $past(pwdata[7:6]) && conv_exp == $past(pwdata[5:3])))
      else $error("quick setup fields wrong");

   a_unmapped_err: assert property (@(posedge ref_clk) disable iff (!reset_n)
      (setup_ph && !mapped) |=> (pslverr && prdata == 32'h00000000))
      else $error("unmapped access not refused");

endmodule

`default_nettype wire

// file: socr_regs_tb.sv
// Self-checking bench for the serial output control register bank.
// Assumes socr_pkg and socr_regs are compiled first; drives APB, samples and flags itself.
`default_nettype none

module socr_regs_tb;
   timeunit 1ns;
   timeprecision 1ps;

   // ***********************************************************
   // Signals
   // ***********************************************************
   logic                          ref_clk;
   logic                          reset_n;
   logic                          psel;
   logic                          penable;
   logic                          pwrite;
   logic [socr_pkg::ADDR_W-1:0]   paddr;
   logic [socr_pkg::DATA_W-1:0]   pwdata;
   logic [socr_pkg::DATA_W-1:0]   prdata;
   logic                          pready;
   logic                          pslverr;
   logic [socr_pkg::SAMPLE_W-1:0] sample_in;
   logic [socr_pkg::SAMPLE_W-1:0] sample_out;
   logic [socr_pkg::NUM_VC-1:0]   or_event;
   logic [socr_pkg::NUM_VC-1:0]   or_flags;
   logic                          pll_locked_pin;
   logic                          lane_rate_low;
   logic [1:0]                    lane_exp;
   logic [2:0]                    conv_exp;
   logic [2:0]                    octet_exp;
   logic [31:0]                   rd;
   logic                          err;
   logic [7:0]                    fmts [4];
   logic [13:0]                   e;
   int                            fail_count;
   int                            samples_checked;
   int                            cycles;

   socr_regs dut_u (.ref_clk(ref_clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .sample_in(sample_in), .sample_out(sample_out), .or_event(or_event), .or_flags(or_flags),
      .pll_locked_pin(pll_locked_pin), .lane_rate_low(lane_rate_low), .lane_exp(lane_exp),
      .conv_exp(conv_exp), .octet_exp(octet_exp));

   // ***********************************************************
   // Clock and hang guard
   // ***********************************************************
   initial begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end

   // Ceiling is far above the roughly 150 cycles the tests need
   initial begin
      cycles = 0;
      forever begin
         @(posedge ref_clk);
         cycles++;
         if (cycles == 5000) begin
            fail_count++;
            tally_and_finish();
         end
      end
   end

   // ***********************************************************
   // Tasks
   // ***********************************************************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // One APB transfer; waits for pready rather than assuming zero wait states
   task automatic apb(input logic [13:0] idx, input logic wr, input logic [7:0] wd);
      int n;
      @(posedge ref_clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= {idx, 2'b00};
      pwdata  <= {24'h000000, wd};
      @(posedge ref_clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      // A slave that never answers ends the run here
      if (n == 50) begin
         fail_count++;
         tally_and_finish();
      end
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rd_chk(input logic [13:0] idx, input logic [7:0] exp);
      apb(idx, 1'b0, 8'h00);
      chk(rd, {24'h000000, exp});
      chk({31'h0, err}, 32'h0);
   endtask

   // Drive one sample and look at the registered result a cycle later
   task automatic samp(input logic [13:0] v, input logic [13:0] exp);
      @(posedge ref_clk);
      sample_in <= v;
      @(posedge ref_clk);
      #1;
      chk({18'h0, sample_out}, {18'h0, exp});
   endtask

   task automatic pulse_or(input logic [3:0] ev);
      @(posedge ref_clk);
      or_event <= ev;
      @(posedge ref_clk);
      or_event <= 4'h0;
      repeat (2) @(posedge ref_clk);
      #1;
   endtask

   task automatic tally_and_finish();
      $display("checks=%0d errors=%0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // ***********************************************************
   // Main sequence
   // ***********************************************************
   initial begin
      fail_count = 0;
      samples_checked = 0;
      reset_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 16'h0000;
      pwdata = 32'h00000000;
      sample_in = 14'h0000;
      or_event = 4'h0;
      pll_locked_pin = 1'b0;
      fmts = '{8'h01, 8'h05, 8'h04, 8'h00};
      repeat (16) @(posedge ref_clk);
      reset_n <= 1'b1;
      #1;
      chk({31'h0, lane_rate_low}, 32'h1);
      chk({24'h0, lane_exp, conv_exp, octet_exp}, 32'h80);
      // Reset values of every register
      rd_chk(socr_pkg::IDX_OUT_FMT, 8'h01);
      rd_chk(socr_pkg::IDX_OR_CLR, 8'h00);
      rd_chk(socr_pkg::IDX_OR_STAT, 8'h00);
      rd_chk(socr_pkg::IDX_RATE, 8'h10);
      rd_chk(socr_pkg::IDX_PLL_STAT, 8'h00);
      rd_chk(socr_pkg::IDX_QUICK, 8'h80);
      // Unmapped place answers with an error and zero data
      apb(14'h0564, 1'b0, 8'h00);
      chk({31'h0, err}, 32'h1);
      chk(rd, 32'h0);
      // Every format and invert combination on one sample
      for (int i = 0; i < 4; i++) begin
         apb(socr_pkg::IDX_OUT_FMT, 1'b1, fmts[i]);
         e = fmts[i][socr_pkg::INV_BIT] ? ~14'h1234 : 14'h1234;
         if (fmts[i][1:0] == socr_pkg::FMT_OFFSET) e = e ^ 14'h2000;
         samp(14'h1234, e);
      end
      apb(socr_pkg::IDX_OUT_FMT, 1'b1, 8'hff);
      rd_chk(socr_pkg::IDX_OUT_FMT, 8'h07);
      // Sticky flag, then clear one converter while others keep theirs
      pulse_or(4'h2);
      chk({28'h0, or_flags}, 32'h2);
      repeat (3) @(posedge ref_clk);
      rd_chk(socr_pkg::IDX_OR_STAT, 8'h02);
      apb(socr_pkg::IDX_OR_CLR, 1'b1, 8'h02);
      pulse_or(4'h3);
      chk({28'h0, or_flags}, 32'h1);
      rd_chk(socr_pkg::IDX_OR_CLR, 8'h02);
      apb(socr_pkg::IDX_OR_CLR, 1'b1, 8'h00);
      #1;
      chk({28'h0, or_flags}, 32'h1);
      apb(socr_pkg::IDX_OR_STAT, 1'b1, 8'h00);
      chk({31'h0, err}, 32'h0);
      rd_chk(socr_pkg::IDX_OR_STAT, 8'h01);
      apb(socr_pkg::IDX_OR_CLR, 1'b1, 8'hff);
      rd_chk(socr_pkg::IDX_OR_CLR, 8'h0f);
      chk({28'h0, or_flags}, 32'h0);
      // Lane rate range
      apb(socr_pkg::IDX_RATE, 1'b1, 8'h00);
      #1;
      chk({31'h0, lane_rate_low}, 32'h0);
      apb(socr_pkg::IDX_RATE, 1'b1, 8'hff);
      rd_chk(socr_pkg::IDX_RATE, 8'h10);
      chk({31'h0, lane_rate_low}, 32'h1);
      // Lock level through the synchroniser; status stays read-only
      @(posedge ref_clk);
      pll_locked_pin <= 1'b1;
      repeat (6) @(posedge ref_clk);
      apb(socr_pkg::IDX_PLL_STAT, 1'b1, 8'h00);
      rd_chk(socr_pkg::IDX_PLL_STAT, 8'h80);
      pll_locked_pin <= 1'b0;
      repeat (6) @(posedge ref_clk);
      rd_chk(socr_pkg::IDX_PLL_STAT, 8'h00);
      // Quick setup exponents
      apb(socr_pkg::IDX_QUICK, 1'b1, 8'h9b);
      rd_chk(socr_pkg::IDX_QUICK, 8'h9b);
      chk({24'h0, lane_exp, conv_exp, octet_exp}, 32'h9b);
      // Reset in mid-run brings written registers back to their defaults
      @(posedge ref_clk);
      reset_n <= 1'b0;
      repeat (2) @(posedge ref_clk);
      reset_n <= 1'b1;
      rd_chk(socr_pkg::IDX_QUICK, 8'h80);
      rd_chk(socr_pkg::IDX_OR_CLR, 8'h00);
      rd_chk(socr_pkg::IDX_RATE, 8'h10);
      chk({24'h0, lane_exp, conv_exp, octet_exp}, 32'h80);
      tally_and_finish();
   end

endmodule

`default_nettype wire
